// File: verilog/i2sap_port.sv
// i2sap_port: two-channel serial audio transmitter, bit clock master or slave
// assumes pins are sampled synchronously to I_CLK and slave SCK is far below I_CLK
// Functional notes
// - master drives SCK/WS, slave takes them in
// - SDO is always an output
// - sixteen-bit words, MSB first
// - words left-justified in channel slot
// - MSB one bit clock after WS change
// - data changes on falling SCK only
// - left when WS low, right when high
// - master: 48 kHz, 32 or 50 bits
// - master SCK from fractional N/M divider
// - slave accepts any SCK up to 3.072 MHz
// - master SCK high/low each at least 0.35T
`timescale 1ns/1ps
module i2sap_port
    import i2sap_pkg::*;
#(
    parameter logic [15:0] P_DIV_N_32 = DIV_N_32,
    parameter logic [15:0] P_DIV_M_32 = DIV_M_32,
    parameter logic [15:0] P_DIV_N_50 = DIV_N_50,
    parameter logic [15:0] P_DIV_M_50 = DIV_M_50,
    parameter int          P_DEPTH    = FIFO_DEPTH
) (
    input  wire logic              I_CLK,
    input  wire logic              I_SRST,
    input  wire logic              I_MASTER,
    input  wire logic              I_RATE50,
    input  wire logic              I_SCK,
    output logic                   O_SCK,
    output logic                   O_SCK_OE,
    input  wire logic              I_WS,
    output logic                   O_WS,
    output logic                   O_WS_OE,
    output logic                   O_SDO,
    input  wire logic              I_SAMPLE_VALID,
    output logic                   O_SAMPLE_READY,
    input  wire logic [WORD_W-1:0] I_SAMPLE_LEFT,
    input  wire logic [WORD_W-1:0] I_SAMPLE_RIGHT,
    output logic                   O_UNDERRUN
);
    logic [ACC_W-1:0]    acc_q;
    logic                msck_q;
    logic                mws_q;
    logic [CNT_W-1:0]    mcnt_q;
    logic                sck_prev_q;
    logic                ws_r_q;
    logic                ws_f_q;
    logic [CNT_W-1:0]    bit_q;
    logic [WORD_W-1:0]   sh_q;
    logic [WORD_W-1:0]   right_q;
    logic                sdo_q;
    logic                undr_q;
    logic                sck_cur;
    logic                rise;
    logic                fall;
    logic                tick;
    logic [ACC_W:0]      acc_sum;
    logic [15:0]         div_n;
    logic [15:0]         div_m;
    logic [CNT_W-1:0]    slot_len;
    logic                ws_change;
    logic                fifo_valid;
    logic                fifo_pop;
    logic [2*WORD_W-1:0] fifo_data;

    // half-period add step and modulus for the selected frame length
    function automatic logic [15:0] div_sel(input logic rate50,
                                            input logic [15:0] a50,
                                            input logic [15:0] a32);
        return rate50 ? a50 : a32;
    endfunction

    assign div_n    = div_sel(I_RATE50, P_DIV_N_50, P_DIV_N_32);
    assign div_m    = div_sel(I_RATE50, P_DIV_M_50, P_DIV_M_32);
    assign slot_len = I_RATE50 ? SLOT_BITS_L : SLOT_BITS_S;
    assign acc_sum  = {1'b0, acc_q} + {1'b0, div_n};
    assign tick     = (acc_sum >= {1'b0, div_m});

    // phase accumulator: halves differ by at most one reference cycle,
    // so both phases stay near 0.5T, well above 0.35T
    always_ff @(posedge I_CLK) begin
        if (I_SRST || !I_MASTER) begin
            acc_q  <= '0;
            msck_q <= 1'b0;
        end else if (tick) begin
            acc_q  <= ACC_W'(acc_sum - {1'b0, div_m});
            msck_q <= ~msck_q;
        end else begin
            acc_q <= ACC_W'(acc_sum);
        end
    end

    assign O_SCK    = msck_q;
    assign O_SCK_OE = I_MASTER;
    assign O_WS     = mws_q;
    assign O_WS_OE  = I_MASTER;
    assign O_SDO    = sdo_q;

    assign sck_cur = I_MASTER ? msck_q : I_SCK;
    assign rise    = sck_cur && !sck_prev_q;
    assign fall    = !sck_cur && sck_prev_q;

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_cur;
        end
    end

    // master word select flips on the falling edge that ends each slot
    always_ff @(posedge I_CLK) begin
        if (I_SRST || !I_MASTER) begin
            mws_q  <= 1'b0;
            mcnt_q <= CNT_ZERO;
        end else if (fall) begin
            if (mcnt_q == slot_len - CNT_ONE) begin
                mcnt_q <= CNT_ZERO;
                mws_q  <= ~mws_q;
            end else begin
                mcnt_q <= mcnt_q + CNT_ONE;
            end
        end
    end

    // word select is captured on rising edges in both modes
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ws_r_q <= 1'b0;
        end else if (rise) begin
            ws_r_q <= I_MASTER ? mws_q : I_WS;
        end
    end

    assign ws_change = fall && (ws_r_q != ws_f_q);
    assign fifo_pop  = ws_change && !ws_r_q;

    // shifter: the change seen at a rising edge is acted on at the next
    // falling edge, which puts the MSB one bit period after WS moved
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ws_f_q  <= 1'b0;
            bit_q   <= CNT_ZERO;
            sh_q    <= '0;
            right_q <= '0;
            sdo_q   <= 1'b0;
        end else if (ws_change) begin
            ws_f_q <= ws_r_q;
            bit_q  <= CNT_ONE;
            if (!ws_r_q) begin
                // underrun sends silence rather than stale audio
                sdo_q   <= fifo_valid && fifo_data[2*WORD_W-1];
                sh_q    <= fifo_valid ? {fifo_data[2*WORD_W-2:WORD_W], 1'b0} : '0;
                right_q <= fifo_valid ? fifo_data[WORD_W-1:0] : '0;
            end else begin
                sdo_q <= right_q[WORD_W-1];
                sh_q  <= {right_q[WORD_W-2:0], 1'b0};
            end
        end else if (fall) begin
            if (bit_q < CNT_W'(WORD_W)) begin
                sdo_q <= sh_q[WORD_W-1];
                sh_q  <= {sh_q[WORD_W-2:0], 1'b0};
                bit_q <= bit_q + CNT_ONE;
            end else begin
                sdo_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            undr_q <= 1'b0;
        end else begin
            undr_q <= fifo_pop && !fifo_valid;
        end
    end

    assign O_UNDERRUN = undr_q;

    i2sap_fifo #(
        .WIDTH (2*WORD_W),
        .DEPTH (P_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLK),
        .i_srst      (I_SRST),
        .i_in_valid  (I_SAMPLE_VALID),
        .o_in_ready  (O_SAMPLE_READY),
        .i_in_data   ({I_SAMPLE_LEFT, I_SAMPLE_RIGHT}),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_data)
    );
endmodule // i2sap_port

// File: verilog/i2sap_pkg.sv
// i2sap_pkg: constants shared by the serial audio port and its checker
// assumes a 200 MHz reference clock feeding the whole block
package i2sap_pkg;
    localparam int          REF_CLK_HZ     = 200_000_000;
    localparam int          FRAME_HZ       = 48_000;
    localparam int          WORD_W         = 16;
    localparam int          FRAME_BITS_S   = 32;
    localparam int          FRAME_BITS_L   = 50;
    localparam int          SLAVE_MAX_HZ   = 3_072_000;
    localparam int          CNT_W          = 6;
    localparam int          ACC_W          = 16;
    localparam int          FIFO_DEPTH     = 8;
    // half-period tick rate = 2 * bit rate = REF * N / M
    localparam logic [15:0] DIV_N_32       = 16'h0030;
    localparam logic [15:0] DIV_M_32       = 16'h0C35;
    localparam logic [15:0] DIV_N_50       = 16'h0003;
    localparam logic [15:0] DIV_M_50       = 16'h007D;
    localparam logic [5:0]  SLOT_BITS_S    = 6'h10;
    localparam logic [5:0]  SLOT_BITS_L    = 6'h19;
    localparam logic [5:0]  CNT_ONE        = 6'h01;
    localparam logic [5:0]  CNT_ZERO       = 6'h00;
endpackage

// File: verilog/i2sap_fifo.sv
// i2sap_fifo: synchronous fifo with valid/ready on both sides
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ps
module i2sap_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // i2sap_fifo

// File: bench/i2sap_chk.sv
// i2sap_chk: port-level checks for the serial audio port
// assumes it is bound to i2sap_port and sees only its ports
`timescale 1ns/1ps
module i2sap_chk
    import i2sap_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_MASTER,
    input wire logic I_RATE50,
    input wire logic I_SCK,
    input wire logic O_SCK,
    input wire logic O_SCK_OE,
    input wire logic O_WS,
    input wire logic O_WS_OE,
    input wire logic O_SDO
);
    logic       ws_q;
    logic       sck_q;
    logic       armed_q;
    logic [5:0] falls_q;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    // the first word select change after reset only arms the slot count
    always_ff @(posedge I_CLK) begin
        ws_q    <= O_WS;
        sck_q   <= O_SCK;
        falls_q <= (I_SRST || O_WS != ws_q) ? CNT_ZERO : falls_q + {5'h0, sck_q & ~O_SCK};
        armed_q <= !I_SRST && (armed_q || O_WS != ws_q);
    end
    a_sck_oe: assert property (O_SCK_OE == I_MASTER) else $error("sck enable");
    a_ws_oe: assert property (O_WS_OE == I_MASTER) else $error("ws enable");
    a_sdo_mfall: assert property (I_MASTER && $changed(O_SDO) |-> !O_SCK && !$past(O_SCK))
        else $error("sdo moved, sck high");
    a_sdo_sfall: assert property (!I_MASTER && $changed(O_SDO) |-> !I_SCK && !$past(I_SCK))
        else $error("sdo moved, sck high");
    a_ws_on_low: assert property (I_MASTER && $changed(O_WS) |-> !O_SCK ##1 !O_SCK)
        else $error("ws off falling edge");
    a_sck_high: assert property (I_MASTER && $rose(O_SCK) |-> O_SCK [*3])
        else $error("sck high short");
    a_sck_low: assert property (I_MASTER && $fell(O_SCK) |-> !O_SCK [*3])
        else $error("sck low short");
    a_sck_runs: assert property (I_MASTER && $changed(O_SCK) |=> ##[0:70] $changed(O_SCK))
        else $error("sck stalled");
    a_slot_len: assert property (I_MASTER && armed_q && O_WS != ws_q
        |-> falls_q == (I_RATE50 ? SLOT_BITS_L : SLOT_BITS_S)) else $error("slot length");
endmodule // i2sap_chk

bind i2sap_port i2sap_chk CHK (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_MASTER(I_MASTER),
    .I_RATE50(I_RATE50), .I_SCK(I_SCK), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE), .O_WS(O_WS),
    .O_WS_OE(O_WS_OE), .O_SDO(O_SDO));

// File: bench/i2sap_codec.sv
// i2sap_codec: far-side codec, bit clock source when the port is slave
// assumes i_sck and i_ws are the resolved bus lines
`timescale 1ns/1ps
module i2sap_codec (
    input  wire logic i_run,
    input  wire logic i_sck,
    input  wire logic i_ws,
    input  wire logic i_sdo,
    output logic      o_sck,
    output logic      o_ws,
    output int        o_pad_err
);
    logic [16:0] rx_q[$];
    logic [15:0] sr;
    logic        ws_p = 1'b0;
    logic        ch;
    int          cnt = 17;
    int          bits = 0;
    initial begin
        o_pad_err = 0;
        o_sck = 1'b0;
        o_ws = 1'b0;
        forever begin
            #165;
            // the clock runs while i_run is high and stands still at the end of a frame once i_run drops
            if (i_run || bits != 0 || o_sck) begin
                o_sck = ~o_sck;
                if (!o_sck) begin
                    bits = (bits + 1) % 32;
                    o_ws = (bits >= 16);
                end
            end
        end
    end
    always @(posedge i_sck) begin
        if (cnt < 16) begin
            sr = {sr[14:0], i_sdo};
            cnt++;
            if (cnt == 16) rx_q.push_back({ch, sr});
        end else if (cnt == 16 && i_sdo !== 1'b0) o_pad_err++;
        if (i_ws != ws_p) begin
            cnt = 0;
            ch = i_ws;
        end
        ws_p = i_ws;
    end
endmodule // i2sap_codec

// File: bench/i2sap_port_tb.sv
// i2sap_port_tb: self-checking bench for the serial audio port
// assumes the codec model on the far side and the bound checker
`timescale 1ns/1ps
module i2sap_port_tb;
    logic        I_CLK, I_SRST, I_MASTER, I_RATE50, I_SAMPLE_VALID, c_run, under, synced;
    logic        O_SCK, O_SCK_OE, O_WS, O_WS_OE, O_SDO, O_SAMPLE_READY, O_UNDERRUN, c_sck, c_ws;
    logic [15:0] I_SAMPLE_LEFT, I_SAMPLE_RIGHT;
    logic [31:0] exp_q[$];
    logic [31:0] cur;
    logic [16:0] w;
    int          num_errors = 0, n_tests = 0, nleft = 0, pad_err;
    integer      seed = 32'h0000_ca41;
    wire         sck_w = O_SCK_OE ? O_SCK : c_sck;
    wire         ws_w = O_WS_OE ? O_WS : c_ws;
    i2sap_port #(.P_DIV_N_32(16'h0001), .P_DIV_M_32(16'h0004), .P_DIV_N_50(16'h0001),
        .P_DIV_M_50(16'h0004)) DUT (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_MASTER(I_MASTER),
        .I_RATE50(I_RATE50), .I_SCK(sck_w), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE), .I_WS(ws_w),
        .O_WS(O_WS), .O_WS_OE(O_WS_OE), .O_SDO(O_SDO), .I_SAMPLE_VALID(I_SAMPLE_VALID),
        .O_SAMPLE_READY(O_SAMPLE_READY), .I_SAMPLE_LEFT(I_SAMPLE_LEFT),
        .I_SAMPLE_RIGHT(I_SAMPLE_RIGHT), .O_UNDERRUN(O_UNDERRUN));
    i2sap_codec CODEC (.i_run(c_run), .i_sck(sck_w), .i_ws(ws_w), .i_sdo(O_SDO),
        .o_sck(c_sck), .o_ws(c_ws), .o_pad_err(pad_err));
    initial begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bail;
        num_errors++;
        report_and_stop();
    endtask
    task automatic push(input logic [31:0] s);
        int n = 0;
        I_SAMPLE_VALID = 1'b1;
        {I_SAMPLE_LEFT, I_SAMPLE_RIGHT} = s;
        while (O_SAMPLE_READY !== 1'b1) begin
            if (++n > 20000) bail();
            @(negedge I_CLK);
        end
        @(negedge I_CLK);
        exp_q.push_back(s);
    endtask
    task automatic run_case(input logic m, input logic r, input int np, input int nl);
        int n = 0;
        I_SRST = 1'b1;
        @(negedge I_CLK);
        I_MASTER = m;
        I_RATE50 = r;
        repeat (20) @(negedge I_CLK);
        CODEC.cnt = 17;
        CODEC.ws_p = 1'b0;
        CODEC.rx_q.delete();
        exp_q.delete();
        synced = 1'b0;
        I_SRST = 1'b0;
        for (int i = 0; i < np; i++) push($random(seed));
        // slave case: the codec clock is still, so the fifo must refuse
        if (!m) begin
            check({15'h0000, O_SAMPLE_READY}, 16'h0000);
            {I_SAMPLE_LEFT, I_SAMPLE_RIGHT} = $random(seed);
            repeat (4) @(negedge I_CLK);
        end
        I_SAMPLE_VALID = 1'b0;
        under = 1'b0;
        c_run = !m;
        nl += nleft;
        while (nleft < nl) begin
            if (++n > 30000) bail();
            @(negedge I_CLK);
        end
        c_run = 1'b0;
        check(pad_err[15:0], 16'h0000);
        $display("test master %0d rate50 %0d done", m, r);
    endtask
    always @(negedge I_CLK) begin
        if (O_UNDERRUN === 1'b1) under = 1'b1;
        while (CODEC.rx_q.size() > 0) begin
            w = CODEC.rx_q.pop_front();
            if (!w[16]) begin
                synced = 1'b1;
                nleft++;
                // an empty queue at a left slot must have raised the underrun pulse
                check({15'h0000, under}, {15'h0000, exp_q.size() == 0});
                cur = (exp_q.size() == 0) ? 32'h0000_0000 : exp_q.pop_front();
                under = 1'b0;
                check(w[15:0], cur[31:16]);
            end else if (synced) check(w[15:0], cur[15:0]);
        end
    end
    initial begin
        {I_SRST, I_MASTER, I_RATE50, I_SAMPLE_VALID, c_run} = 5'h10;
        {I_SAMPLE_LEFT, I_SAMPLE_RIGHT} = 32'h0000_0000;
        run_case(1'b1, 1'b0, 6, 8);
        run_case(1'b1, 1'b1, 3, 5);
        run_case(1'b0, 1'b0, 8, 10);
        report_and_stop();
    end
endmodule // i2sap_port_tb
